// [src/pvcr_consts.vh]
// constants for the vendor control and configuration register bank
// assumes a clause-22 style management frame engine sits in the register bank that includes it
// Behaviour
// - link control enable resets to the autonomy strap value
// - mode field: 0000 keep, 0011 normal, 1100 standby, 1011 sleep request
// - retrain bit 9 pulses a training restart and reads back zero
// - test field 8:6: none, modes one to five, bypass, reserved
// - cable test bit 5 starts test with one, stops with zero; the code only pulses a start on one, a zero write stops nothing
// - configuration words writable only while unlock bit 2 is set
// - in disable mode inhibit output follows inhibit configuration bit
// - wake request bit 0 makes transmitter send idle symbols
// - role bit 15 of word one: one master, zero slave
// - role, autonomy, interface and address bits reset from straps
// - interface field: MII, RMII 50 MHz ref, RMII crystal, reverse MII
// - sleep handshake bit 6 demands peer confirmation before sleep
// - indicator enable bit 3 shares pin between indicator and wake
// - with indicator off, wake honoured only in sleep, sleep req, standby
// - sleep-on-request bit 0 moves normal to sleep request on group
// - address 15:11 is 001 plus two strap bits, feeds scrambler seed
// - averaging field selects 32, 64, 128 or 256 symbols
// - thresholds: 000 none, 001..111 class A..G; warn A, fail none
// - bad-symbol counter counts at most once per packet
// - counter saturates at FFFF, clears on read, survives link disable
// - link disable returns link status bits to defaults
`ifndef PVCR_CONSTS_VH
`define PVCR_CONSTS_VH
`define PVCR_REG_EXT_CTRL   5'h11
`define PVCR_REG_CFG1       5'h12
`define PVCR_REG_CFG2       5'h13
`define PVCR_REG_SYMCNT     5'h14
`define PVCR_ADDR_HI        3'h1
`define PVCR_MODE_KEEP      4'h0
`define PVCR_MODE_NORMAL    4'h3
`define PVCR_MODE_STANDBY   4'hC
`define PVCR_MODE_SLEEPREQ  4'hB
`define PVCR_OPM_DISABLE    3'h0
`define PVCR_OPM_NORMAL     3'h1
`define PVCR_OPM_STANDBY    3'h2
`define PVCR_OPM_SLEEPREQ   3'h3
`define PVCR_OPM_SLEEP      3'h4
`define PVCR_EXT_RST_LOW    15'h0002
`define PVCR_CFG1_RST_MASK  16'h3CA3
`define PVCR_CFG2_RST       11'h05
`define PVCR_CFG2_RST_LO    11'h045
`define PVCR_CFG1_RST       16'h0811
`define PVCR_SMI_PREAMBLE   6'h20
`endif

// [src/pvcr_sync.v]
// two-flop synchroniser bank for pins from outside the core clock domain
// assumes the core reset is already released synchronously
`timescale 1ns/100ps
module pvcr_sync #(
  parameter W = 1
) (
  input  wire         clk_in,
  input  wire         rst_b_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  // first stage feeds only the second stage
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule

// [src/pvcr_regs.v]
// vendor control/config register bank behind the serial management port
// assumes MDC and MDIO are raw pins; straps stable at reset release
`timescale 1ns/100ps
`include "pvcr_consts.vh"
module pvcr_regs (
  input  wire        CORE_CLK_IN,
  input  wire        RST_B_IN,
  input  wire        MDC_IN,
  input  wire        MDIO_IN,
  output wire        MDIO_OUT,
  output wire        MDIO_OE_OUT,
  input  wire        STRAP_ROLE_IN,
  input  wire        STRAP_AUTO_IN,
  input  wire [1:0]  STRAP_MII_IN,
  input  wire [1:0]  STRAP_ADDR_IN,
  input  wire        SYM_ERR_IN,
  input  wire        PKT_END_IN,
  input  wire        LPS_GROUP_IN,
  input  wire        PEER_CONFIRM_IN,
  input  wire        LINK_UP_IN,
  input  wire        RX_FRAME_IN,
  input  wire        CARRIER_IN,
  input  wire        WAKE_PIN_IN,
  output reg  [2:0]  OP_MODE_OUT,
  output reg         CTRL_FAULT_OUT,
  output reg         RETRAIN_OUT,
  output reg         CABLE_TEST_OUT,
  output reg  [2:0]  TEST_MODE_OUT,
  output reg         SCR_BYPASS_OUT,
  output reg  [1:0]  LOOPBACK_OUT,
  output reg         LINK_CTRL_OUT,
  output reg         INHIBIT_OUT,
  output reg         WAKE_IDLE_TX_OUT,
  output reg         ROLE_MASTER_OUT,
  output reg  [1:0]  MAC_IF_OUT,
  output reg  [8:0]  AVG_SYMBOLS_OUT,
  output reg  [2:0]  WARN_THRESH_OUT,
  output reg  [2:0]  FAIL_THRESH_OUT,
  output reg  [4:0]  SCR_SEED_OUT,
  output reg         INDICATOR_OUT,
  output reg         INDICATOR_OE_OUT,
  output reg         LOCAL_WAKE_OUT,
  output reg         LINK_STATUS_OUT
);
  // reset release through two flops
  reg rst_m_q;
  reg rst_s_q;
  always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  wire rst_b = rst_s_q;

  // pins sampled into the core domain
  wire [2:0] pin_s;
  pvcr_sync #(.W(3)) u_sync (
    .clk_in   (CORE_CLK_IN),
    .rst_b_in (rst_b),
    .async_in ({MDC_IN, MDIO_IN, WAKE_PIN_IN}),
    .sync_out (pin_s)
  );
  wire mdc_s  = pin_s[2];
  wire mdio_s = pin_s[1];
  wire wake_s = pin_s[0];
  reg  mdc_q;
  always @(posedge CORE_CLK_IN or negedge rst_b) begin
    if (!rst_b) mdc_q <= 1'b0;
    else        mdc_q <= mdc_s;
  end
  wire mdc_rise = mdc_s & ~mdc_q;
  wire mdc_fall = ~mdc_s & mdc_q;

  // strap capture one cycle after release, not in the async branch
  reg straps_done_q;
  reg [5:0] strap_q;
  always @(posedge CORE_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      straps_done_q <= 1'b0;
      strap_q       <= 6'h00;
    end else if (!straps_done_q) begin
      straps_done_q <= 1'b1;
      strap_q <= {STRAP_ROLE_IN, STRAP_AUTO_IN, STRAP_MII_IN, STRAP_ADDR_IN};
    end
  end

  // management frame engine: preamble, start, op, phy addr, reg addr, data
  localparam S_IDLE = 2'h0;
  localparam S_HDR  = 2'h1;
  localparam S_DATA = 2'h2;
  reg [1:0]  st_q;
  reg [5:0]  pre_q;
  reg [4:0]  cnt_q;
  reg [13:0] hdr_q;
  reg [15:0] sh_q;
  reg        oe_q;
  reg        wr_stb;
  reg        rd_stb;
  reg [15:0] rd_data;
  wire [4:0] my_addr = {`PVCR_ADDR_HI, strap_q[1:0]};
  wire       hdr_ok  = hdr_q[13:12] == 2'h1 && hdr_q[9:5] == my_addr;
  wire       is_rd   = hdr_q[11:10] == 2'h2;
  wire       is_wr   = hdr_q[11:10] == 2'h1;
  wire [4:0] reg_a   = hdr_q[4:0];

  always @(posedge CORE_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= S_IDLE;
      pre_q  <= 6'h00;
      cnt_q  <= 5'h00;
      hdr_q  <= 14'h0000;
      sh_q   <= 16'h0000;
      oe_q   <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (mdc_rise) begin
        case (st_q)
          S_IDLE: begin
            if (mdio_s) begin
              if (pre_q != `PVCR_SMI_PREAMBLE) pre_q <= pre_q + 6'h01;
            end else if (pre_q == `PVCR_SMI_PREAMBLE) begin
              st_q  <= S_HDR;
              cnt_q <= 5'h00;
              hdr_q <= 14'h0000;
            end else begin
              pre_q <= 6'h00;
            end
          end
          S_HDR: begin
            // start bit zero already seen; collect 13 more header bits
            hdr_q <= {hdr_q[12:0], mdio_s};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h0C) begin
              st_q  <= S_DATA;
              cnt_q <= 5'h00;
            end
          end
          S_DATA: begin
            cnt_q <= cnt_q + 5'h01;
            if (!oe_q) sh_q <= {sh_q[14:0], mdio_s};
            if (cnt_q == 5'h11) begin
              st_q  <= S_IDLE;
              pre_q <= 6'h00;
              oe_q  <= 1'b0;
              if (hdr_ok && is_wr) wr_stb <= 1'b1;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
      // turnaround then drive read data on falling edges
      if (mdc_fall && st_q == S_DATA) begin
        if (cnt_q == 5'h01 && hdr_ok && is_rd) begin
          oe_q   <= 1'b1;
          sh_q   <= rd_data;
          rd_stb <= 1'b1;
        end else if (oe_q && cnt_q > 5'h02) begin
          sh_q <= {sh_q[14:0], 1'b0};
        end
      end
      if (st_q == S_HDR) hdr_q[13] <= 1'b0;
    end
  end
  assign MDIO_OUT    = sh_q[15];
  assign MDIO_OE_OUT = oe_q;

  // register storage
  reg [14:0] ext_q;      // bits 14:0 of the control word
  reg        link_q;
  reg [15:0] cfg1_q;
  reg [10:0] cfg2_q;
  reg [15:0] symcnt_q;
  reg        pkt_hit_q;
  wire unlock = ext_q[2];
  wire [3:0] mode_req = sh_q[14:11];
  wire mode_bad = mode_req != `PVCR_MODE_KEEP &&
                  mode_req != `PVCR_MODE_NORMAL &&
                  mode_req != `PVCR_MODE_STANDBY &&
                  mode_req != `PVCR_MODE_SLEEPREQ;

  always @(*) begin
    case (reg_a)
      `PVCR_REG_EXT_CTRL: rd_data = {link_q, 4'h0, ext_q[10], 1'b0,
                                     ext_q[8:6], 1'b0, ext_q[4:0]};
      `PVCR_REG_CFG1:     rd_data = {cfg1_q[15:13], 1'b0, cfg1_q[11:0]};
      `PVCR_REG_CFG2:     rd_data = {my_addr, cfg2_q};
      `PVCR_REG_SYMCNT:   rd_data = symcnt_q;
      default:            rd_data = 16'h0000;
    endcase
  end

  // control, configuration and mode state
  always @(posedge CORE_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      ext_q          <= `PVCR_EXT_RST_LOW;
      link_q         <= 1'b0;
      cfg1_q         <= `PVCR_CFG1_RST;
      cfg2_q         <= `PVCR_CFG2_RST_LO;
      OP_MODE_OUT    <= `PVCR_OPM_DISABLE;
      CTRL_FAULT_OUT <= 1'b0;
      RETRAIN_OUT    <= 1'b0;
      CABLE_TEST_OUT <= 1'b0;
    end else begin
      CTRL_FAULT_OUT <= 1'b0;
      RETRAIN_OUT    <= 1'b0;
      CABLE_TEST_OUT <= 1'b0;  // one-cycle command, not a level
      if (straps_done_q == 1'b0) begin
        link_q <= STRAP_AUTO_IN;
        cfg1_q[15:14] <= {STRAP_ROLE_IN, STRAP_AUTO_IN};
        cfg1_q[9:8]   <= STRAP_MII_IN;
      end
      if (wr_stb && reg_a == `PVCR_REG_EXT_CTRL) begin
        link_q     <= sh_q[15];
        ext_q[10]  <= sh_q[10];
        ext_q[8:0] <= {sh_q[8:6], 1'b0, sh_q[4:0]};
        RETRAIN_OUT <= sh_q[9];
        CABLE_TEST_OUT <= sh_q[5];
        if (mode_bad) CTRL_FAULT_OUT <= 1'b1;
        else if (mode_req == `PVCR_MODE_NORMAL)
          OP_MODE_OUT <= `PVCR_OPM_NORMAL;
        else if (mode_req == `PVCR_MODE_STANDBY)
          OP_MODE_OUT <= `PVCR_OPM_STANDBY;
        else if (mode_req == `PVCR_MODE_SLEEPREQ)
          OP_MODE_OUT <= `PVCR_OPM_SLEEPREQ;
      end else begin
        ext_q[5] <= 1'b0;
        // automatic sleep request on low-power code group
        if (OP_MODE_OUT == `PVCR_OPM_NORMAL && LPS_GROUP_IN && cfg1_q[0])
          OP_MODE_OUT <= `PVCR_OPM_SLEEPREQ;
        else if (OP_MODE_OUT == `PVCR_OPM_SLEEPREQ &&
                 (!cfg1_q[6] || PEER_CONFIRM_IN))
          OP_MODE_OUT <= `PVCR_OPM_SLEEP;
      end
      if (wr_stb && reg_a == `PVCR_REG_CFG1 && unlock)
        cfg1_q <= {sh_q[15:13], 1'b0, sh_q[11:0]};
      if (wr_stb && reg_a == `PVCR_REG_CFG2 && unlock)
        cfg2_q <= sh_q[10:0];
    end
  end

  // bad-symbol counter, once per packet, saturating, clear on read
  always @(posedge CORE_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      symcnt_q  <= 16'h0000;
      pkt_hit_q <= 1'b0;
    end else begin
      if (PKT_END_IN) pkt_hit_q <= 1'b0;
      else if (SYM_ERR_IN) pkt_hit_q <= 1'b1;
      // an error in the read cycle itself still counts
      if (rd_stb && reg_a == `PVCR_REG_SYMCNT)
        symcnt_q <= {15'h0000, SYM_ERR_IN & ~pkt_hit_q};
      else if (SYM_ERR_IN && !pkt_hit_q && symcnt_q != 16'hFFFF)
        symcnt_q <= symcnt_q + 16'h0001;
    end
  end

  // decoded outputs registered from the stored words
  always @(posedge CORE_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      TEST_MODE_OUT    <= 3'h0;
      SCR_BYPASS_OUT   <= 1'b0;
      LOOPBACK_OUT     <= 2'h0;
      LINK_CTRL_OUT    <= 1'b0;
      INHIBIT_OUT      <= 1'b1;
      WAKE_IDLE_TX_OUT <= 1'b0;
      ROLE_MASTER_OUT  <= 1'b0;
      MAC_IF_OUT       <= 2'h0;
      AVG_SYMBOLS_OUT  <= 9'h020;
      WARN_THRESH_OUT  <= 3'h1;
      FAIL_THRESH_OUT  <= 3'h0;
      SCR_SEED_OUT     <= 5'h00;
      INDICATOR_OUT    <= 1'b0;
      INDICATOR_OE_OUT <= 1'b0;
      LOCAL_WAKE_OUT   <= 1'b0;
      LINK_STATUS_OUT  <= 1'b0;
    end else begin
      // codes 1..5 are test modes, 6 bypass, 7 reserved acts as none
      TEST_MODE_OUT  <= (ext_q[8:6] <= 3'h5) ? ext_q[8:6] : 3'h0;
      SCR_BYPASS_OUT <= ext_q[8:6] == 3'h6;
      LOOPBACK_OUT   <= ext_q[4:3];
      LINK_CTRL_OUT  <= link_q;
      INHIBIT_OUT    <= (OP_MODE_OUT == `PVCR_OPM_DISABLE) ?
                        ext_q[1] : 1'b1;
      WAKE_IDLE_TX_OUT <= ext_q[0];
      ROLE_MASTER_OUT  <= cfg1_q[15];
      MAC_IF_OUT       <= cfg1_q[9:8];
      AVG_SYMBOLS_OUT  <= 9'h020 << cfg2_q[10:9];
      WARN_THRESH_OUT  <= cfg2_q[8:6];
      FAIL_THRESH_OUT  <= cfg2_q[5:3];
      SCR_SEED_OUT     <= my_addr;
      INDICATOR_OE_OUT <= cfg1_q[3];
      case (cfg1_q[5:4])
        2'h0:    INDICATOR_OUT <= cfg1_q[3] & LINK_UP_IN;
        2'h1:    INDICATOR_OUT <= cfg1_q[3] & RX_FRAME_IN;
        2'h2:    INDICATOR_OUT <= cfg1_q[3] & SYM_ERR_IN;
        default: INDICATOR_OUT <= cfg1_q[3] & CARRIER_IN;
      endcase
      LOCAL_WAKE_OUT <= ~cfg1_q[3] & wake_s &
                        (OP_MODE_OUT == `PVCR_OPM_SLEEP ||
                         OP_MODE_OUT == `PVCR_OPM_SLEEPREQ ||
                         OP_MODE_OUT == `PVCR_OPM_STANDBY);
      LINK_STATUS_OUT <= link_q & LINK_UP_IN;
    end
  end
endmodule

// [sim/pvcr_chk.sv]
// checker: timing relations seen at the register bank's top ports
// assumes bind from the bench top; straps steady while running
`timescale 1ns/100ps
module pvcr_chk (
  input wire       CORE_CLK_IN,
  input wire       RST_B_IN,
  input wire       STRAP_ROLE_IN,
  input wire       STRAP_AUTO_IN,
  input wire [1:0] STRAP_MII_IN,
  input wire [1:0] STRAP_ADDR_IN,
  input wire [2:0] OP_MODE_OUT,
  input wire       CTRL_FAULT_OUT,
  input wire       RETRAIN_OUT,
  input wire       CABLE_TEST_OUT,
  input wire       LINK_CTRL_OUT,
  input wire       ROLE_MASTER_OUT,
  input wire [1:0] MAC_IF_OUT,
  input wire [8:0] AVG_SYMBOLS_OUT,
  input wire [4:0] SCR_SEED_OUT,
  input wire       INDICATOR_OUT,
  input wire       INDICATOR_OE_OUT,
  input wire       LOCAL_WAKE_OUT,
  input wire       LINK_STATUS_OUT
);
  reg [3:0] cyc_q;
  // cycles since release; stops at 15, so the strap check fires once and the seed check on every later cycle
  always @(posedge CORE_CLK_IN or negedge RST_B_IN)
    if (!RST_B_IN) cyc_q <= 4'h0;
    else if (cyc_q != 4'hF) cyc_q <= cyc_q + 4'h1;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  a_fault_pulse: assert property (CTRL_FAULT_OUT |=> !CTRL_FAULT_OUT)
    else $error("fault pulse too long");
  a_retrain_once: assert property (RETRAIN_OUT |=> !RETRAIN_OUT)
    else $error("retrain pulse too long");
  a_cable_once: assert property ($rose(CABLE_TEST_OUT) |=> !CABLE_TEST_OUT)
    else $error("cable test pulse too long");
  a_strap_reset: assert property (cyc_q == 4'hA |->
    ROLE_MASTER_OUT == STRAP_ROLE_IN && MAC_IF_OUT == STRAP_MII_IN
    && LINK_CTRL_OUT == STRAP_AUTO_IN) else $error("strap reset wrong");
  a_seed_strap: assert property (cyc_q == 4'hF |->
    SCR_SEED_OUT == {3'h1, STRAP_ADDR_IN}) else $error("seed wrong");
  a_ind_shared: assert property ((INDICATOR_OE_OUT || !INDICATOR_OUT) &&
    (!INDICATOR_OE_OUT || !LOCAL_WAKE_OUT)) else $error("pin share wrong");
  a_wake_modes: assert property (LOCAL_WAKE_OUT |-> OP_MODE_OUT inside
    {3'h2, 3'h3, 3'h4} || $past(OP_MODE_OUT) inside {3'h2, 3'h3, 3'h4})
    else $error("wake outside low power modes");
  a_link_dflt: assert property (!LINK_CTRL_OUT [*2] |-> !LINK_STATUS_OUT)
    else $error("link status while disabled");
  a_avg_legal: assert property (AVG_SYMBOLS_OUT inside
    {9'h020, 9'h040, 9'h080, 9'h100}) else $error("bad averaging");
endmodule

// [sim/pvcr_smi_model.sv]
// management controller model: clause-22 frames on MDC and MDIO
// assumes the bench resolves MDIO with a pull-up and feeds it back
`timescale 1ns/100ps
module pvcr_smi_model (
  input  wire clk_in,
  input  wire mdio_in,
  output reg  mdc_out,
  output reg  mdio_out,
  output reg  mdio_oe_out
);
  // MDC stands low and MDIO floats between frames
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
  end
  // one bit, 160 ns: drive while MDC low, sample just before the rise
  task automatic slot(input logic drv, input logic v, output logic s);
    mdio_oe_out = drv;
    mdio_out = v;
    mdc_out = 1'b0;
    repeat (8) @(negedge clk_in);
    s = mdio_in;
    mdc_out = 1'b1;
    repeat (8) @(negedge clk_in);
  endtask
  // whole frame; on a read the line is released from turnaround on
  task automatic xfer(input logic rd, input logic [4:0] ra,
    input logic [1:0] pa, input logic [15:0] wd, output logic [15:0] q);
    logic [13:0] hdr;
    logic        s;
    integer      i;
    hdr = {2'b01, rd, !rd, 3'h1, pa, ra};
    for (i = 0; i < 32; i++) slot(1'b1, 1'b1, s);
    for (i = 13; i >= 0; i--) slot(1'b1, hdr[i], s);
    slot(!rd, 1'b1, s);
    slot(!rd, 1'b0, s);
    for (i = 15; i >= 0; i--) begin
      slot(!rd, wd[i], s);
      q[i] = s;
    end
    mdio_oe_out = 1'b0;
    mdc_out = 1'b0;
    repeat (8) @(negedge clk_in);
  endtask
endmodule

// [sim/tb_top.sv]
// bench top: register bank driven by a management controller model
// assumes 100 MHz core clock; other inputs change on the falling edge
`timescale 1ns/100ps
`include "pvcr_consts.vh"
module tb_top;
  reg         clk = 1'b0, rst_b = 1'b0, sym = 1'b0, pend = 1'b0;
  reg         low_power_sleep_group = 1'b0, peer = 1'b0, lnk = 1'b0, rxf = 1'b0;
  reg         crs = 1'b0, wpin = 1'b0;
  reg  [15:0] r, n_flt = 0, n_rt = 0, n_ct = 0;
  reg  [2:0]  sel;
  integer     fails = 0, cmp_count = 0, i, k;
  wire        mdc, m_o, m_oe, d_o, d_oe, flt, rt, ct, byp, lctl, regulator_inhibit_out;
  wire        wtx, role, ind, ind_oe, lwk, lst;
  wire [2:0]  opm, tmode;
  wire [1:0]  mif;
  wire [8:0]  avg;
  wire [2:0]  wth, fth;
  wire [4:0]  seed;
  // released line falls back to the pull-up level
  wire        mdio = d_oe ? d_o : (m_oe ? m_o : 1'b1);
  always #5 clk = ~clk;
  pvcr_smi_model smi (.clk_in(clk), .mdio_in(mdio), .mdc_out(mdc),
    .mdio_out(m_o), .mdio_oe_out(m_oe));
  pvcr_regs DUT (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .MDC_IN(mdc),
    .MDIO_IN(mdio), .MDIO_OUT(d_o), .MDIO_OE_OUT(d_oe),
    .STRAP_ROLE_IN(1'b1), .STRAP_AUTO_IN(1'b0), .STRAP_MII_IN(2'h2),
    .STRAP_ADDR_IN(2'h2), .SYM_ERR_IN(sym), .PKT_END_IN(pend),
    .LPS_GROUP_IN(low_power_sleep_group), .PEER_CONFIRM_IN(peer), .LINK_UP_IN(lnk),
    .RX_FRAME_IN(rxf), .CARRIER_IN(crs), .WAKE_PIN_IN(wpin),
    .OP_MODE_OUT(opm), .CTRL_FAULT_OUT(flt), .RETRAIN_OUT(rt),
    .CABLE_TEST_OUT(ct), .TEST_MODE_OUT(tmode), .SCR_BYPASS_OUT(byp),
    .LOOPBACK_OUT(), .LINK_CTRL_OUT(lctl), .INHIBIT_OUT(regulator_inhibit_out),
    .WAKE_IDLE_TX_OUT(wtx), .ROLE_MASTER_OUT(role), .MAC_IF_OUT(mif),
    .AVG_SYMBOLS_OUT(avg), .WARN_THRESH_OUT(wth), .FAIL_THRESH_OUT(fth),
    .SCR_SEED_OUT(seed), .INDICATOR_OUT(ind), .INDICATOR_OE_OUT(ind_oe),
    .LOCAL_WAKE_OUT(lwk), .LINK_STATUS_OUT(lst));
  // one-cycle command pulses are counted as they happen
  always @(posedge clk) begin
    if (flt === 1'b1) n_flt <= n_flt + 16'h1;
    if (rt === 1'b1) n_rt <= n_rt + 16'h1;
    if (ct === 1'b1) n_ct <= n_ct + 16'h1;
  end
  task end_sim;
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk_reg(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_bit(input logic g, input logic e);
    chk_reg({15'h0, g}, {15'h0, e});
  endtask
  task wr(input logic [4:0] ra, input logic [15:0] d);
    smi.xfer(1'b0, ra, 2'h2, d, r);
  endtask
  task rd(input logic [4:0] ra, input logic [15:0] e, input logic [15:0] m);
    smi.xfer(1'b1, ra, 2'h2, 16'h0000, r);
    chk_reg(r & m, e & m);
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // watchdog: about twice the expected run
  initial begin
    tick(80000);
    fails++;
    end_sim;
  end
  initial begin
    tick(10);
    rst_b = 1'b1;
    tick(8);
    chk_bit(lctl, 1'b0);
    chk_bit(role, 1'b1);
    chk_reg({14'h0, mif}, 16'h0002);
    chk_reg({11'h0, seed}, 16'h0006);
    chk_reg({7'h0, avg}, 16'h0020);
    chk_reg({10'h0, wth, fth}, 16'h0008);
    rd(`PVCR_REG_EXT_CTRL, 16'h0002, 16'hFFFF);
    rd(`PVCR_REG_CFG2, 16'h3045, 16'hFFFF);
    rd(`PVCR_REG_SYMCNT, 16'h0000, 16'hFFFF);
    wr(`PVCR_REG_CFG1, 16'h0000);
    rd(`PVCR_REG_CFG1, 16'h8211, 16'hE3FF);
    for (i = 0; i < 2; i++) begin
      wr(`PVCR_REG_EXT_CTRL, {14'h1, i[0], 1'b0});
      chk_bit(regulator_inhibit_out, i[0]);
    end
    for (i = 0; i < 4; i++) begin
      wr(`PVCR_REG_EXT_CTRL, {1'b0, 4'(16'h3C05 >> (12 - 4 * i)), 11'h006});
      chk_reg({13'h0, opm}, (i == 0) ? 16'h1 : 16'h2);
    end
    chk_reg(n_flt, 16'h0001);
    wpin = 1'b1;
    tick(4);
    chk_bit(lwk, 1'b1);
    wr(`PVCR_REG_EXT_CTRL, 16'h1A26);
    chk_bit(lwk, 1'b0);
    chk_reg({n_rt[7:0], n_ct[7:0]}, 16'h0101);
    rd(`PVCR_REG_EXT_CTRL, 16'h0006, 16'h87FF);
    for (i = 0; i < 8; i++) begin
      wr(`PVCR_REG_EXT_CTRL, {7'h0, i[2:0], 1'b0, i[1:0], 3'h6});
      chk_bit(byp, i == 6);
      if (i != 6) chk_reg({13'h0, tmode}, (i == 7) ? 16'h0 : i);
    end
    chk_reg({13'h0, opm}, 16'h0001);
    wr(`PVCR_REG_EXT_CTRL, 16'h0007);
    chk_bit(wtx, 1'b1);
    wr(`PVCR_REG_EXT_CTRL, 16'h0006);
    chk_bit(wtx, 1'b0);
    smi.xfer(1'b0, `PVCR_REG_CFG1, 2'h1, 16'h0000, r);
    rd(`PVCR_REG_CFG1, 16'h8211, 16'hE3FF);
    for (i = 0; i < 4; i++) if (i != 2) begin
      wr(`PVCR_REG_CFG1, {10'h00D, i[1:0], 4'h8});
      sel = (i == 0) ? 3'h4 : (i == 1) ? 3'h2 : 3'h1;
      for (k = 0; k < 2; k++) begin
        {lnk, rxf, crs} = k ? sel : ~sel;
        tick(4);
        chk_bit(ind, k[0]);
      end
    end
    chk_reg({12'h0, role, ind_oe, mif}, 16'h0007);
    low_power_sleep_group = 1'b1;
    tick(1);
    low_power_sleep_group = 1'b0;
    tick(4);
    chk_reg({13'h0, opm}, 16'h0001);
    lnk = 1'b1;
    wr(`PVCR_REG_EXT_CTRL, 16'h8006);
    chk_bit(lst, 1'b1);
    for (i = 0; i < 6; i++) begin
      sym = 1'b1;
      tick(1);
      sym = 1'b0;
      pend = (i % 3 == 2);
      tick(1);
      pend = 1'b0;
    end
    wr(`PVCR_REG_EXT_CTRL, 16'h0006);
    chk_bit(lst, 1'b0);
    rd(`PVCR_REG_SYMCNT, 16'h0002, 16'hFFFF);
    rd(`PVCR_REG_SYMCNT, 16'h0000, 16'hFFFF);
    wr(`PVCR_REG_CFG1, 16'h0359);
    low_power_sleep_group = 1'b1;
    tick(1);
    low_power_sleep_group = 1'b0;
    tick(4);
    chk_reg({13'h0, opm}, 16'h0003);
    peer = 1'b1;
    tick(4);
    chk_reg({13'h0, opm}, 16'h0004);
    end_sim;
  end
endmodule
bind pvcr_regs pvcr_chk u_chk (.CORE_CLK_IN, .RST_B_IN, .STRAP_ROLE_IN,
  .STRAP_AUTO_IN, .STRAP_MII_IN, .STRAP_ADDR_IN, .OP_MODE_OUT,
  .CTRL_FAULT_OUT, .RETRAIN_OUT, .CABLE_TEST_OUT, .LINK_CTRL_OUT,
  .ROLE_MASTER_OUT, .MAC_IF_OUT, .AVG_SYMBOLS_OUT, .SCR_SEED_OUT,
  .INDICATOR_OUT, .INDICATOR_OE_OUT, .LOCAL_WAKE_OUT, .LINK_STATUS_OUT);
